// *** verilog/integrity_pkg.sv ***
package integrity_pkg;

  // ==========================================
  // Host opcodes
  localparam logic [7:0] OP_SRAM_WR  = 8'h90;
  localparam logic [7:0] OP_CFG_WR   = 8'hc0;
  localparam logic [7:0] OP_PART_RST = 8'h8a;
  localparam logic [7:0] OP_START    = 8'h8c;
  localparam logic [7:0] OP_RES_RD   = 8'h40;
  localparam logic [7:0] OP_OTP_RD   = 8'h20;
  localparam logic [7:0] OP_SRAM_RD  = 8'h10;

  // ==========================================
  // Memory layout
  localparam logic [11:0] CODE_LAST_FULL = 12'hfaa;
  localparam logic [11:0] CODE_LAST_QUAD = 12'h7aa;
  localparam logic [11:0] CFG_BASE       = 12'hfb0;
  localparam logic [12:0] PARITY_OFS     = 13'h1000;
  localparam logic [10:0] BANK_LOW       = 11'h000;

  // ==========================================
  // Configuration bytes and fields
  localparam logic [7:0] CFG_CTRL      = 8'h00;
  localparam logic [7:0] CFG_ECC       = 8'h01;
  localparam logic [7:0] CFG_LOCK      = 8'h02;
  localparam logic [7:0] CFG_SRAM      = 8'h2b;
  localparam logic [7:0] CFG_RUN       = 8'h4d;
  localparam logic [7:0] ECC_DOUBLE    = 8'h0f;
  localparam logic [7:0] ECC_QUAD      = 8'hf0;
  localparam logic [7:0] LOCK_DIS_MASK = 8'hc0;
  localparam int         CMP_EN_BIT    = 0;
  localparam int         SRAM_SEL_BIT  = 0;
  localparam int         RUN_BIT       = 0;

  // ==========================================
  // Status byte
  localparam logic [7:0] STATUS_ADDR = 8'h18;
  localparam int         RATIO_W     = 24;
  localparam int         RATIO_FRAC  = 21;

  typedef enum logic [1:0] {MODE_DIRECT, MODE_DOUBLE, MODE_QUAD} mode_t;

  // Hamming check bits over one code byte
  function automatic logic [3:0] ham_check(input logic [7:0] d);
    return {d[4] ^ d[5] ^ d[6] ^ d[7],
            d[1] ^ d[2] ^ d[3] ^ d[7],
            d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6],
            d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6]};
  endfunction

  function automatic logic [7:0] ham_fix(input logic [7:0] d, input logic [3:0] s);
    logic [7:0] f;
    f = d;
    case (s)
      4'h3: f[0] = ~d[0];
      4'h5: f[1] = ~d[1];
      4'h6: f[2] = ~d[2];
      4'h7: f[3] = ~d[3];
      4'h9: f[4] = ~d[4];
      4'ha: f[5] = ~d[5];
      4'hb: f[6] = ~d[6];
      4'hc: f[7] = ~d[7];
      default: f = d;
    endcase
    return f;
  endfunction

endpackage

// *** verilog/fetch_if.sv ***
`timescale 1ns/10ps
interface fetch_if;
  logic        req;
  logic        raw;
  logic [12:0] addr;
  logic        done;
  logic [7:0]  data;
  modport client (output req, output raw, output addr, input done, input data);
  modport server (input req, input raw, input addr, output done, output data);
endinterface

// *** verilog/program_sram.sv ***
`timescale 1ns/10ps
module program_sram (
  // Clock
  input  wire logic        clk,
  // Write port
  input  wire logic        we,
  input  wire logic [11:0] waddr,
  input  wire logic [7:0]  wdata,
  // Read port
  input  wire logic [11:0] raddr,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [0:4095];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// *** verilog/otp_fetch.sv ***
`timescale 1ns/10ps
module otp_fetch import integrity_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Fetch requests
  fetch_if.server          f,
  input  wire mode_t       mode,
  // OTP array
  output logic      [12:0] otp_addr,
  output logic             otp_rd,
  input  wire logic [7:0]  otp_rdata
);
  typedef enum logic [1:0] {F_IDLE, F_ISSUE, F_CAP} fst_t;

  fst_t        st_reg;
  logic [1:0]  k_reg;
  logic [12:0] base_reg;
  logic        raw_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  data_reg;
  logic        done_reg;

  wire         single = raw_reg || mode == MODE_DIRECT;
  wire  [1:0]  last_k = single ? 2'h0 : (mode == MODE_DOUBLE) ? 2'h1 : 2'h3;
  wire  [1:0]  k_nxt  = k_reg + 2'h1;
  // Quad banks sit 2k apart, parity bytes 4k above the code
  wire  [12:0] ofs    = (mode == MODE_QUAD) ? {k_nxt, BANK_LOW} : (k_nxt[0] ? PARITY_OFS : 13'h0000);
  // Blank cells read ones, so an unwritten bank never masks a bit
  wire  [7:0]  fin    = single ? otp_rdata :
                        (mode == MODE_QUAD) ? (acc_reg & otp_rdata) :
                        ham_fix(acc_reg, ham_check(acc_reg) ^ otp_rdata[3:0]);

  assign f.done = done_reg;
  assign f.data = data_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg   <= F_IDLE;
      k_reg    <= 2'h0;
      base_reg <= 13'h0000;
      raw_reg  <= 1'b0;
      acc_reg  <= 8'hff;
      data_reg <= 8'h00;
      done_reg <= 1'b0;
      otp_addr <= 13'h0000;
      otp_rd   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      otp_rd   <= 1'b0;
      unique case (st_reg)
        F_IDLE: begin
          if (f.req) begin
            base_reg <= f.addr;
            otp_addr <= f.addr;
            raw_reg  <= f.raw;
            k_reg    <= 2'h0;
            otp_rd   <= 1'b1;
            st_reg   <= F_ISSUE;
          end
        end
        F_ISSUE: st_reg <= F_CAP;
        F_CAP: begin
          acc_reg <= (k_reg == 2'h0) ? otp_rdata : (acc_reg & otp_rdata);
          if (k_reg == last_k) begin
            data_reg <= fin;
            done_reg <= 1'b1;
            st_reg   <= F_IDLE;
          end else begin
            k_reg    <= k_nxt;
            otp_addr <= base_reg + ofs;
            otp_rd   <= 1'b1;
            st_reg   <= F_ISSUE;
          end
        end
      endcase
    end
  end

  chk_direct_one_read: assert property (@(posedge clk) disable iff (!rst_b)
    st_reg == F_IDLE && f.req && (f.raw || mode == MODE_DIRECT) |-> ##3 done_reg)
    else $error("direct fetch not done in 3 cycles");
  chk_double_parity_read: assert property (@(posedge clk) disable iff (!rst_b)
    st_reg == F_IDLE && f.req && !f.raw && mode == MODE_DOUBLE |-> !done_reg [*5] ##1 done_reg)
    else $error("double fetch not done in 5 cycles");
  chk_quad_four_reads: assert property (@(posedge clk) disable iff (!rst_b)
    st_reg == F_IDLE && f.req && !f.raw && mode == MODE_QUAD |-> ##1 otp_rd ##2 otp_rd ##2 otp_rd ##2 otp_rd ##2 done_reg)
    else $error("quad fetch did not read four banks");
endmodule

// *** verilog/otp_integrity.sv ***
`timescale 1ns/10ps
module otp_integrity import integrity_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Pins
  input  wire logic        autoboot_pin,
  input  wire logic        ring_osc_pin,
  // Processor
  input  wire logic        cpu_idle,
  input  wire logic [11:0] cpu_addr,
  output logic      [7:0]  cpu_rdata,
  output logic             cpu_hold,
  // Host byte link
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        frame_end,
  output logic             tx_valid,
  output logic      [7:0]  tx_byte,
  // Measurement
  output logic             meas_reset,
  output logic             meas_start,
  output logic             converter_run_flag,
  output logic      [7:0]  res_addr,
  input  wire logic [7:0]  res_rdata,
  // OTP array
  output logic      [12:0] otp_addr,
  output logic             otp_rd,
  input  wire logic [7:0]  otp_rdata,
  // Status
  output logic             por_flag_sram,
  output logic             readout_protection,
  output logic             sram_compare_enable
);
  typedef enum logic [2:0] {S_CFG_REQ, S_CFG_WAIT, S_COPY_REQ, S_COPY_WAIT,
                            S_IDLE, S_CMP_WAIT, S_HOST_WAIT} mst_t;
  typedef enum logic [1:0] {P_OP, P_AH, P_AL, P_DATA} pst_t;
  typedef enum logic [1:0] {C_SRAM_WR, C_CFG_WR, C_RES_RD, C_MEM_RD} cmd_t;

  // ==========================================
  // State
  mst_t        state_reg;
  pst_t        pst_reg;
  cmd_t        cmd_reg;
  logic [1:0]  cfg_idx_reg;
  logic [11:0] mem_addr_reg;
  logic [11:0] cmp_addr_reg;
  logic [11:0] haddr_reg;
  logic        src_sram_reg;
  logic        hreq_reg;
  logic        rreq_reg;
  logic        cmp_en_reg;
  logic        sram_sel_reg;
  logic        run_reg;
  mode_t       mode_reg;
  logic        protect_reg;
  logic        copied_reg;
  logic        por_flag_reg;
  logic        tx_valid_reg;
  logic [7:0]  tx_byte_reg;
  logic        meas_reset_reg;
  logic        meas_start_reg;
  logic        boot_s1, boot_s2;
  logic        ring_s1, ring_s2;
  logic [7:0]  sram_rdata;

  fetch_if fb ();

  // ==========================================
  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      boot_s1 <= 1'b0;
      boot_s2 <= 1'b0;
      ring_s1 <= 1'b0;
      ring_s2 <= 1'b0;
    end else begin
      boot_s1 <= autoboot_pin;
      boot_s2 <= boot_s1;
      ring_s1 <= ring_osc_pin;
      ring_s2 <= ring_s1;
    end
  end

  // ==========================================
  // Decoding
  wire [11:0] code_last = (mode_reg == MODE_QUAD) ? CODE_LAST_QUAD : CODE_LAST_FULL;
  wire [7:0]  cfg_off   = (cfg_idx_reg == 2'h0) ? CFG_CTRL : (cfg_idx_reg == 2'h1) ? CFG_ECC :
                          (cfg_idx_reg == 2'h2) ? CFG_LOCK : CFG_SRAM;
  wire        boot_busy = state_reg inside {S_CFG_REQ, S_CFG_WAIT, S_COPY_REQ, S_COPY_WAIT};
  wire        cmp_ok    = cmp_en_reg && sram_sel_reg && copied_reg && ring_s2;
  wire        host_go   = state_reg == S_IDLE && hreq_reg;
  wire        cmp_go    = state_reg == S_IDLE && !hreq_reg && cmp_ok && cpu_idle;
  wire        cfg_done  = state_reg == S_CFG_WAIT && fb.done;
  wire        mismatch  = state_reg == S_CMP_WAIT && fb.done && fb.data != sram_rdata;
  wire        refused   = protect_reg && (!src_sram_reg || sram_sel_reg);
  wire        host_done = state_reg == S_HOST_WAIT && (src_sram_reg || fb.done);
  wire [7:0]  host_byte = refused ? 8'h00 : (src_sram_reg ? sram_rdata : fb.data);
  wire        byte_in   = rx_valid && !frame_end;
  wire        data_in   = byte_in && pst_reg == P_DATA;
  wire        cfg_wr    = data_in && cmd_reg == C_CFG_WR;
  wire        copy_we   = state_reg == S_COPY_WAIT && fb.done;
  wire        host_we   = data_in && cmd_reg == C_SRAM_WR && !boot_busy;
  wire        is_stat   = haddr_reg[7:0] == STATUS_ADDR;
  // Results pass through untouched except the status byte, whose bits 5, 4 and 0 carry POR flag, boot busy and run: three bytes each, low byte at the lowest address
  wire [7:0]  res_byte  = is_stat ? {res_rdata[7:6], por_flag_reg, boot_busy, res_rdata[3:1], run_reg}
                                  : res_rdata;
  wire        mem_req_set = byte_in && cmd_reg == C_MEM_RD && (pst_reg == P_AL || pst_reg == P_DATA);

  assign fb.req  = state_reg == S_CFG_REQ || state_reg == S_COPY_REQ || cmp_go ||
                   (host_go && !src_sram_reg);
  assign fb.raw  = state_reg == S_CFG_REQ || host_go;
  assign fb.addr = (state_reg == S_CFG_REQ) ? {1'b0, CFG_BASE + {4'h0, cfg_off}} :
                   host_go ? {1'b0, haddr_reg} :
                   (state_reg == S_COPY_REQ) ? {1'b0, mem_addr_reg} : {1'b0, cmp_addr_reg};

  wire [11:0] sram_raddr = (cmp_go || state_reg == S_CMP_WAIT) ? cmp_addr_reg :
                           host_go ? haddr_reg : cpu_addr;
  // Copy writes the fetched byte verbatim, no pattern merged in
  wire [11:0] sram_waddr = copy_we ? mem_addr_reg : haddr_reg;
  wire [7:0]  sram_wdata = copy_we ? fb.data : rx_byte;

  // ==========================================
  // Memories
  otp_fetch fetch_u (
    .clk       (clk),
    .rst_b     (rst_b),
    .f         (fb.server),
    .mode      (mode_reg),
    .otp_addr  (otp_addr),
    .otp_rd    (otp_rd),
    .otp_rdata (otp_rdata)
  );

  program_sram sram_u (
    .clk   (clk),
    .we    (copy_we || host_we),
    .waddr (sram_waddr),
    .wdata (sram_wdata),
    .raddr (sram_raddr),
    .rdata (sram_rdata)
  );

  // ==========================================
  // Boot, copy and background compare
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg    <= S_CFG_REQ;
      cfg_idx_reg  <= 2'h0;
      mem_addr_reg <= 12'h000;
      cmp_addr_reg <= 12'h000;
      copied_reg   <= 1'b0;
      por_flag_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_CFG_REQ: state_reg <= S_CFG_WAIT;
        S_CFG_WAIT: begin
          if (fb.done) begin
            cfg_idx_reg  <= cfg_idx_reg + 2'h1;
            mem_addr_reg <= 12'h000;
            if (cfg_idx_reg != 2'h3) begin
              state_reg <= S_CFG_REQ;
            end else if (boot_s2 && fb.data[SRAM_SEL_BIT]) begin
              state_reg <= S_COPY_REQ;
            end else begin
              state_reg <= S_IDLE;
            end
          end
        end
        S_COPY_REQ: state_reg <= S_COPY_WAIT;
        S_COPY_WAIT: begin
          if (fb.done) begin
            mem_addr_reg <= mem_addr_reg + 12'h001;
            if (mem_addr_reg == code_last) begin
              copied_reg <= 1'b1;
              state_reg  <= S_IDLE;
            end else begin
              state_reg <= S_COPY_REQ;
            end
          end
        end
        S_IDLE: begin
          if (host_go) begin
            state_reg <= S_HOST_WAIT;
          end else if (cmp_go) begin
            state_reg <= S_CMP_WAIT;
          end
        end
        S_CMP_WAIT: begin
          if (mismatch) begin
            // Whole power-on sequence again: configuration, copy, processor restart
            por_flag_reg <= 1'b1;
            copied_reg   <= 1'b0;
            cfg_idx_reg  <= 2'h0;
            cmp_addr_reg <= 12'h000;
            state_reg    <= S_CFG_REQ;
          end else if (fb.done) begin
            cmp_addr_reg <= (cmp_addr_reg == code_last) ? 12'h000 : cmp_addr_reg + 12'h001;
            state_reg    <= S_IDLE;
          end
        end
        S_HOST_WAIT: begin
          if (host_done) begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Configuration held by the device
  always_ff @(posedge clk) begin
    if (!rst_b || mismatch) begin
      cmp_en_reg   <= 1'b0;
      sram_sel_reg <= 1'b0;
      run_reg      <= 1'b0;
      mode_reg     <= MODE_DIRECT;
      protect_reg  <= 1'b0;
    end else if (cfg_done) begin
      // Mode and lock change only here and when a compare mismatch clears them, while no program fetch runs
      unique case (cfg_idx_reg)
        2'h0: cmp_en_reg   <= fb.data[CMP_EN_BIT];
        2'h1: mode_reg     <= (fb.data == ECC_DOUBLE) ? MODE_DOUBLE :
                              (fb.data == ECC_QUAD) ? MODE_QUAD : MODE_DIRECT;
        2'h2: protect_reg  <= (fb.data & LOCK_DIS_MASK) == 8'h00;
        2'h3: sram_sel_reg <= fb.data[SRAM_SEL_BIT];
      endcase
    end else if (cfg_wr) begin
      if (haddr_reg[7:0] == CFG_CTRL) begin
        cmp_en_reg <= rx_byte[CMP_EN_BIT];
      end
      if (haddr_reg[7:0] == CFG_SRAM) begin
        sram_sel_reg <= rx_byte[SRAM_SEL_BIT];
      end
      if (haddr_reg[7:0] == CFG_RUN) begin
        run_reg <= rx_byte[RUN_BIT];
      end
    end
  end

  // ==========================================
  // Host command parser
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pst_reg        <= P_OP;
      cmd_reg        <= C_SRAM_WR;
      haddr_reg      <= 12'h000;
      src_sram_reg   <= 1'b0;
      hreq_reg       <= 1'b0;
      rreq_reg       <= 1'b0;
      meas_reset_reg <= 1'b0;
      meas_start_reg <= 1'b0;
    end else begin
      meas_reset_reg <= 1'b0;
      meas_start_reg <= 1'b0;
      rreq_reg       <= byte_in && cmd_reg == C_RES_RD && (pst_reg == P_AL || pst_reg == P_DATA);
      hreq_reg       <= mem_req_set || (hreq_reg && !host_go);
      if (frame_end) begin
        pst_reg <= P_OP;
      end else if (rx_valid) begin
        unique case (pst_reg)
          P_OP: begin
            case (rx_byte)
              OP_SRAM_WR: begin
                cmd_reg <= C_SRAM_WR;
                pst_reg <= P_AH;
              end
              OP_CFG_WR: begin
                cmd_reg <= C_CFG_WR;
                pst_reg <= P_AL;
              end
              OP_RES_RD: begin
                cmd_reg <= C_RES_RD;
                pst_reg <= P_AL;
              end
              OP_OTP_RD, OP_SRAM_RD: begin
                cmd_reg      <= C_MEM_RD;
                src_sram_reg <= rx_byte == OP_SRAM_RD;
                pst_reg      <= P_AH;
              end
              OP_PART_RST: meas_reset_reg <= 1'b1;
              OP_START:    meas_start_reg <= 1'b1;
              default:     pst_reg <= P_OP;
            endcase
          end
          P_AH: begin
            haddr_reg[11:8] <= rx_byte[3:0];
            pst_reg         <= P_AL;
          end
          P_AL: begin
            haddr_reg[7:0] <= rx_byte;
            if (cmd_reg != C_SRAM_WR && cmd_reg != C_MEM_RD) begin
              haddr_reg[11:8] <= 4'h0;
            end
            pst_reg <= P_DATA;
          end
          P_DATA: haddr_reg <= haddr_reg + 12'h001;
        endcase
      end
    end
  end

  // ==========================================
  // Answers to the host
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_valid_reg <= 1'b0;
      tx_byte_reg  <= 8'h00;
    end else begin
      tx_valid_reg <= host_done || rreq_reg;
      if (host_done) begin
        tx_byte_reg <= host_byte;
      end else if (rreq_reg) begin
        tx_byte_reg <= res_byte;
      end
    end
  end

  assign cpu_rdata           = sram_rdata;
  assign cpu_hold            = boot_busy;
  assign tx_valid            = tx_valid_reg;
  assign tx_byte             = tx_byte_reg;
  assign meas_reset          = meas_reset_reg;
  assign meas_start          = meas_start_reg;
  assign converter_run_flag  = run_reg;
  assign res_addr            = haddr_reg[7:0];
  assign por_flag_sram       = por_flag_reg;
  assign readout_protection  = protect_reg;
  assign sram_compare_enable = cmp_en_reg;

  // ==========================================
  // Checks
  chk_restart_on_mismatch: assert property (@(posedge clk) disable iff (!rst_b)
    mismatch |=> state_reg == S_CFG_REQ && por_flag_reg && cpu_hold && !copied_reg)
    else $error("mismatch did not restart boot");
  chk_compare_when_idle: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == S_IDLE && fb.req && !fb.raw |-> cpu_idle ##1 state_reg == S_CMP_WAIT)
    else $error("compare started while processor busy");
  chk_compare_gating: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(state_reg == S_CMP_WAIT) |-> $past(cmp_en_reg && sram_sel_reg && copied_reg && ring_s2))
    else $error("compare ran without its conditions");
  chk_lock_at_por: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg != S_CFG_WAIT && !mismatch |=> $stable(protect_reg))
    else $error("protection changed outside power-on load");
  chk_mode_frozen: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg_done && !mismatch |=> $stable(mode_reg))
    else $error("redundancy mode changed outside power-on load");
  chk_refused_zero: assert property (@(posedge clk) disable iff (!rst_b)
    host_done && refused |=> tx_valid_reg && tx_byte_reg == 8'h00)
    else $error("protected memory was read out");
  chk_start_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    byte_in && pst_reg == P_OP && rx_byte == OP_START |=> meas_start_reg ##1 !meas_start_reg)
    else $error("start command gave no single pulse");
  chk_partial_reset: assert property (@(posedge clk) disable iff (!rst_b)
    byte_in && pst_reg == P_OP && rx_byte == OP_PART_RST |=> meas_reset_reg && !meas_start_reg)
    else $error("partial reset command gave no pulse");
endmodule

// *** testbench/otp_model.sv ***
`timescale 1ns/10ps
module otp_model (
  // Clock
  input  wire logic        clk,
  // Read port
  input  wire logic        otp_rd,
  input  wire logic [12:0] otp_addr,
  output logic      [7:0]  otp_rdata
);
  logic [7:0] mem [0:8191];
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    otp_rdata = 8'h00;
  end
  // Data valid one cycle only, then toggles so stale reads show
  always @(posedge clk) begin
    if (otp_rd) otp_rdata <= mem[otp_addr];
    else otp_rdata <= ~otp_rdata;
  end
endmodule

// *** testbench/otp_integrity_bench.sv ***
`timescale 1ns/10ps
module otp_integrity_bench import integrity_pkg::*;;
  logic clk = 0, rst_b = 0, autoboot_pin = 0, ring_osc_pin = 1, cpu_idle = 0;
  logic rx_valid = 0, frame_end = 0, tx_valid, cpu_hold, meas_reset, meas_start;
  logic converter_run_flag, otp_rd, por_flag_sram, readout_protection, sram_compare_enable;
  logic [11:0] cpu_addr = 12'h000;
  logic [12:0] otp_addr;
  logic [7:0]  rx_byte = 8'h00, cpu_rdata, tx_byte, res_addr, otp_rdata, last_tx;
  int          err_total = 0, check_count = 0, n_rst = 0, n_go = 0, cyc = 0;
  always #2 clk = ~clk;
  otp_integrity otp_integrity_inst (.clk(clk), .rst_b(rst_b), .autoboot_pin(autoboot_pin),
    .ring_osc_pin(ring_osc_pin), .cpu_idle(cpu_idle), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata),
    .cpu_hold(cpu_hold), .rx_valid(rx_valid), .rx_byte(rx_byte), .frame_end(frame_end),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .meas_reset(meas_reset), .meas_start(meas_start),
    .converter_run_flag(converter_run_flag), .res_addr(res_addr), .res_rdata(~res_addr),
    .otp_addr(otp_addr), .otp_rd(otp_rd), .otp_rdata(otp_rdata), .por_flag_sram(por_flag_sram),
    .readout_protection(readout_protection), .sram_compare_enable(sram_compare_enable));
  otp_model otp_model_inst (.clk(clk), .otp_rd(otp_rd), .otp_addr(otp_addr), .otp_rdata(otp_rdata));
  // ==========================================
  // Observers
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid) last_tx <= tx_byte;
    if (meas_reset) n_rst <= n_rst + 1;
    if (meas_start) n_go <= n_go + 1;
    if (cyc == 90000) begin
      err_total++;
      conclude();
    end
  end
  // ==========================================
  // Host tasks
  task automatic snd(input logic [7:0] b);
    @(posedge clk) begin rx_valid <= 1; rx_byte <= b; end
    @(posedge clk) rx_valid <= 0;
    repeat (16) @(posedge clk);
  endtask
  task automatic fe();
    @(posedge clk) frame_end <= 1;
    @(posedge clk) frame_end <= 0;
    repeat (4) @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic boot();
    int i;
    @(posedge clk) rst_b <= 0;
    repeat (6) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 40000 && cpu_hold !== 1'b0; i++) @(posedge clk);
    if (cpu_hold !== 1'b0) err_total++;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    int i;
    boot();
    // Preload after time zero, clear of the blank fill in the model
    otp_model_inst.mem[5] = 8'ha5;
    chk({7'h0, readout_protection}, 8'h00);
    snd(OP_CFG_WR); snd(CFG_RUN); snd(8'h01); fe();
    chk({7'h0, converter_run_flag}, 8'h01);
    snd(OP_RES_RD); snd(STATUS_ADDR);
    chk(last_tx, 8'hc7);
    snd(8'h00);
    chk(last_tx, 8'he6);
    fe(); snd(OP_PART_RST); fe(); snd(OP_START); fe();
    chk(n_rst[7:0], 8'h01);
    chk(n_go[7:0], 8'h01);
    snd(OP_OTP_RD); snd(8'h00); snd(8'h05);
    chk(last_tx, 8'ha5);
    fe();
    snd(OP_SRAM_WR); snd(8'h00); snd(8'h05); snd(8'h5a); fe();
    snd(OP_SRAM_RD); snd(8'h00); snd(8'h05);
    chk(last_tx, 8'h5a);
    fe();
    $display("test direct done");
    // Lock, quad mode, no compare, SRAM run
    otp_model_inst.mem[12'hfb0] = 8'h00;
    otp_model_inst.mem[12'hfb1] = ECC_QUAD;
    otp_model_inst.mem[12'hfb2] = 8'h00;
    otp_model_inst.mem[12'hfbb] = 8'h01;
    otp_model_inst.mem[13'h0003] = 8'hf3;
    otp_model_inst.mem[13'h0803] = 8'h3f;
    otp_model_inst.mem[13'h1803] = 8'h7f;
    repeat (20) @(posedge clk);
    chk({7'h0, readout_protection}, 8'h00);
    autoboot_pin <= 1;
    boot();
    chk({7'h0, readout_protection}, 8'h01);
    snd(OP_SRAM_RD); snd(8'h00); snd(8'h05);
    chk(last_tx, 8'h00);
    fe(); snd(OP_RES_RD); snd(STATUS_ADDR);
    chk(last_tx, 8'hc6);
    fe(); snd(OP_OTP_RD); snd(8'h00); snd(8'h05);
    chk(last_tx, 8'h00);
    fe();
    cpu_addr <= 12'h003;
    repeat (3) @(posedge clk);
    chk(cpu_rdata, 8'h33);
    $display("test quad lock done");
    snd(OP_SRAM_WR); snd(8'h00); snd(8'h03); snd(8'h00); fe();
    snd(OP_OTP_RD); snd(8'h00); snd(8'h03); fe();
    chk(cpu_rdata, 8'h00);
    snd(OP_CFG_WR); snd(CFG_CTRL); snd(8'h01); fe();
    chk({7'h0, sram_compare_enable}, 8'h01);
    repeat (200) @(posedge clk);
    chk({7'h0, por_flag_sram}, 8'h00);
    cpu_idle <= 1;
    for (i = 0; i < 20000 && por_flag_sram !== 1'b1; i++) @(posedge clk);
    chk({7'h0, por_flag_sram}, 8'h01);
    for (i = 0; i < 40000 && cpu_hold !== 1'b0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(cpu_rdata, 8'h33);
    chk({7'h0, cpu_hold}, 8'h00);
    chk({7'h0, sram_compare_enable}, 8'h00);
    $display("test compare done");
    // Double mode: code byte 3 has one flipped bit that its parity byte mends
    otp_model_inst.mem[12'hfb1] = ECC_DOUBLE;
    otp_model_inst.mem[13'h0003] = 8'h5b;
    otp_model_inst.mem[13'h1003] = 8'h00;
    boot();
    chk(cpu_rdata, 8'h5a);
    $display("test double done");
    conclude();
  end
endmodule
